// ==== periodic_wakeup_counter_regs.sv ====
// Periodic wakeup counter: source select, prescaler, 8-bit modulo counter.
// Assumes source clock inputs and debug level are synchronous to core_clk
// and much slower than it; bus strobes are single cycle.
//
// Overview of operation
// - Match flag in bit 7 sets on the step after the counter reaches the modulo value.
// - Writing 1 to the flag clears it and the request; 0 keeps it.
// - Bits 6-5 pick source: 00 low-power 1 kHz, 01 external, 1x internal.
// - Changing the clock select clears prescaler and counter.
// - Interrupt request while flag set and enable bit 4 is one.
// - Changing the prescaler select clears prescaler and counter.
// - Select bit 0 low: code 0 off, binary then decimal divide table.
// - Select bit 0 high: code 0 off, 2^10..2^16, then 1000..200000.
// - Count register reads the live count; writes to it are ignored.
// - Counter clears on reset, modulo write, or changed select fields.
// - On match the counter reloads zero and the flag sets.
// - Modulo zero sets the flag on every prescaler output edge.
// - Any modulo write stores the value and clears prescaler and counter.
// - Reset clears flag, select fields, enable and the modulo value.
// - Counting holds in background debug, resumes from held value.
// - Flag sets on the same step that takes the counter to zero.
`timescale 1ns/1ps
`include "rtc_defines.svh"

module periodic_wakeup_counter_regs
    import rtc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic low_power_1khz_oscillator,
    input wire logic external_reference_clock,
    input wire logic internal_reference_clock,
    input wire logic debug_active,
    output logic irq
);

    reg_req_t req;
    status_control_t sc;
    logic [7:0] count;
    logic [7:0] modulo;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [`DIV_W-1:0] presc;
    logic [2:0] src_vec;
    logic [2:0] src_prev;
    logic [2:0] src_rise;
    logic src_edge;
    logic [`DIV_W-1:0] div;
    logic [`DIV_W-1:0] term;
    logic wr_sc;
    logic wr_mod;
    logic fields_changed;
    logic clr;
    logic run;
    logic tick;
    logic match_set;
    logic rd_ist;
    logic [7:0] next_rdata;
    localparam logic [`DIV_CODES*`DIV_W-1:0] div_lo_tbl = `DIV_LO_TBL;
    localparam logic [`DIV_CODES*`DIV_W-1:0] div_hi_tbl = `DIV_HI_TBL;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign wr_sc = req.wr && (req.addr == `OFS_SC);
    assign wr_mod = req.wr && (req.addr == `OFS_MOD);
    assign rd_ist = req.rd && (req.addr == `OFS_IST);

    // A write of identical field values does not restart the count
    assign fields_changed = wr_sc &&
        ((req.wdata[`CLKS_HI:`CLKS_LO] != sc.clock_select_field) ||
         (req.wdata[`PS_HI:`PS_LO] != sc.prescaler_select_field));
    assign clr = wr_mod || fields_changed;

    // Edge detect per source; history kept for all so a switch sees no stale edge
    assign src_vec = {internal_reference_clock, external_reference_clock,
                      low_power_1khz_oscillator};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_src
            assign src_rise[gi] = src_vec[gi] && !src_prev[gi];
        end
    endgenerate

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            src_prev <= 3'h0;
        end else begin
            src_prev <= src_vec;
        end
    end

    always_comb begin
        unique case (sc.clock_select_field)
            `CLKS_LPO: src_edge = src_rise[`SRC_LPO];
            `CLKS_EXT: src_edge = src_rise[`SRC_EXT];
            default: src_edge = src_rise[`SRC_INT];
        endcase
    end

    // Divider lookup; select bit 0 picks the table
    always_comb begin
        if (sc.clock_select_field[0]) begin
            div = div_hi_tbl[sc.prescaler_select_field * `DIV_W +: `DIV_W];
        end else begin
            div = div_lo_tbl[sc.prescaler_select_field * `DIV_W +: `DIV_W];
        end
        term = div - `DIV_ONE;
    end

    // Debug freezes both prescaler and counter so counting resumes in place
    assign run = (sc.prescaler_select_field != `PS_OFF) && !debug_active;
    assign tick = run && src_edge && (presc == term) && !clr;
    assign match_set = tick && (count == modulo);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            presc <= `PRE_ZERO;
        end else if (clr) begin
            presc <= `PRE_ZERO;
        end else if (run && src_edge) begin
            presc <= (presc == term) ? `PRE_ZERO : presc + `DIV_ONE;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= `BYTE_ZERO;
        end else if (clr) begin
            count <= `BYTE_ZERO;
        end else if (match_set) begin
            count <= `BYTE_ZERO;
        end else if (tick) begin
            count <= count + 8'h01;
        end
    end

    // Count register has no write path at all
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            modulo <= `BYTE_ZERO;
        end else if (wr_mod) begin
            modulo <= req.wdata;
        end
    end

    // One process owns the register; software keeps the chosen source running
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sc.match_flag <= 1'b0;
            sc.clock_select_field <= `CLKS_LPO;
            sc.match_irq_enable <= 1'b0;
            sc.prescaler_select_field <= `PS_OFF;
        end else begin
            if (wr_sc) begin
                sc.clock_select_field <= req.wdata[`CLKS_HI:`CLKS_LO];
                sc.match_irq_enable <= req.wdata[`IE_BIT];
                sc.prescaler_select_field <= req.wdata[`PS_HI:`PS_LO];
            end
            // Set beats a same-cycle write-one clear, so no match is lost
            if (match_set) begin
                sc.match_flag <= 1'b1;
            end else if (wr_sc && req.wdata[`FLAG_BIT]) begin
                sc.match_flag <= 1'b0;
            end
        end
    end

    // System event status: read clears, set wins over the clearing read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= `BYTE_ZERO;
        end else begin
            irq_status[0] <= match_set || (irq_status[0] && !rd_ist);
            irq_status[7:1] <= 7'h00;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask <= `BYTE_ZERO;
        end else if (req.wr && (req.addr == `OFS_IMSK)) begin
            irq_mask <= {7'h00, req.wdata[0]};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (sc.match_flag && sc.match_irq_enable) ||
                   ((irq_status & irq_mask) != `BYTE_ZERO);
        end
    end

    always_comb begin
        next_rdata = `BYTE_ZERO;
        if (req.rd) begin
            unique case (req.addr)
                `OFS_SC: next_rdata = sc;
                `OFS_CNT: next_rdata = count;
                `OFS_MOD: next_rdata = modulo;
                `OFS_IST: next_rdata = irq_status;
                `OFS_IMSK: next_rdata = irq_mask;
                default: next_rdata = `BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= `BYTE_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_match;
        tick && (count == modulo);
    endsequence

    sequence s_quiet;
        !req.wr && !clr;
    endsequence

    sequence s_flag_clear;
        wr_sc && req.wdata[`FLAG_BIT] && !match_set;
    endsequence

    a_flag_on_match: assert property (
        s_match |=> sc.match_flag && (count == `BYTE_ZERO))
        else $error("flag not set with wrap on match");

    a_flag_w1c: assert property (
        s_flag_clear ##1 !match_set |=> !sc.match_flag &&
            (irq == $past((irq_status & irq_mask) != `BYTE_ZERO)))
        else $error("write one did not clear flag and request");

    a_flag_w0_keep: assert property (
        (wr_sc && !req.wdata[`FLAG_BIT] && sc.match_flag) |=> sc.match_flag)
        else $error("write zero disturbed flag");

    a_irq_follow: assert property (
        (sc.match_flag && sc.match_irq_enable) |=> irq)
        else $error("enabled flag gave no interrupt");

    a_irq_quiet: assert property (
        (!sc.match_irq_enable && irq_mask == `BYTE_ZERO) |=> !irq)
        else $error("interrupt while disabled");

    a_field_clear: assert property (
        fields_changed |=> (count == `BYTE_ZERO) && (presc == `PRE_ZERO))
        else $error("select change did not clear counters");

    a_mod_write: assert property (
        wr_mod |=> (count == `BYTE_ZERO) && (presc == `PRE_ZERO) &&
                   (modulo == $past(req.wdata)))
        else $error("modulo write mishandled");

    a_off_hold: assert property (
        (sc.prescaler_select_field == `PS_OFF) ##0 s_quiet
        |=> $stable(count) && !$rose(sc.match_flag))
        else $error("counter moved while prescaler off");

    a_debug_hold: assert property (
        (debug_active && !clr) [*2] |-> $stable(count) && $stable(presc))
        else $error("counting during debug");

    a_count_read: assert property (
        (req.rd && req.addr == `OFS_CNT) |=> reg_rdata == $past(count))
        else $error("count read wrong");

    a_mod_zero: assert property (
        (tick && modulo == `BYTE_ZERO) |=> sc.match_flag ##0 count == `BYTE_ZERO)
        else $error("modulo zero did not flag");

    a_step_one: assert property (
        (tick && count != modulo) |=> count == $past(count) + 8'h01)
        else $error("counter did not step by one");

    a_event_stat: assert property (
        match_set |=> irq_status[0])
        else $error("match event not recorded");

    a_stat_rd_clr: assert property (
        (rd_ist && !match_set) |=> !irq_status[0])
        else $error("status read did not clear event");

    a_mask_irq: assert property (
        ((irq_status & irq_mask) != `BYTE_ZERO) |=> irq)
        else $error("unmasked event gave no interrupt");

    a_irq_cause: assert property (
        irq |-> $past((sc.match_flag && sc.match_irq_enable) ||
                      ((irq_status & irq_mask) != `BYTE_ZERO)))
        else $error("interrupt without a cause");

    a_clks_clear: assert property (
        (wr_sc && req.wdata[`CLKS_HI:`CLKS_LO] != sc.clock_select_field)
        |=> (count == `BYTE_ZERO) && (presc == `PRE_ZERO))
        else $error("source change did not clear counters");

    a_ps_clear: assert property (
        (wr_sc && req.wdata[`PS_HI:`PS_LO] != sc.prescaler_select_field)
        |=> (count == `BYTE_ZERO) && (presc == `PRE_ZERO))
        else $error("prescaler change did not clear counters");

    a_same_keep: assert property (
        (wr_sc && !fields_changed && !tick) |=> $stable(count))
        else $error("unchanged select fields cleared the count");

    a_reset_state: assert property (
        $rose(reset_n) |-> (sc == `BYTE_ZERO) && (modulo == `BYTE_ZERO) &&
                           (count == `BYTE_ZERO))
        else $error("state after reset not cleared");

    a_mod_hold: assert property (
        !wr_mod |=> $stable(modulo))
        else $error("modulo changed without a write");

    a_count_bound: assert property (
        count <= modulo)
        else $error("count passed the modulo value");

    a_count_idle: assert property (
        (!tick && !clr) |=> $stable(count))
        else $error("count moved without a prescaler tick");

    a_flag_sticky: assert property (
        (sc.match_flag && !(wr_sc && req.wdata[`FLAG_BIT])) |=> sc.match_flag)
        else $error("flag lost without a clearing write");

    a_flag_cause: assert property (
        $rose(sc.match_flag) |-> $past(match_set))
        else $error("flag rose without a match");

    a_cnt_no_write: assert property (
        (req.wr && req.addr == `OFS_CNT && !tick) |=> $stable(count))
        else $error("write reached the count register");

    a_presc_bound: assert property (
        run |-> presc < div)
        else $error("prescaler passed its divide value");

    a_presc_off: assert property (
        (sc.prescaler_select_field == `PS_OFF) |-> presc == `PRE_ZERO)
        else $error("prescaler not parked while off");

    a_rdata_idle: assert property (
        !req.rd |=> reg_rdata == `BYTE_ZERO)
        else $error("read data outside a read cycle");

    a_sc_read: assert property (
        (req.rd && req.addr == `OFS_SC) |=> reg_rdata == $past(sc))
        else $error("status read wrong");

endmodule : periodic_wakeup_counter_regs

// ==== rtc_defines.svh ====
// Offsets, field positions, reset values and divider tables of the counter.
// Assumes inclusion by bare name; definitions only.
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define ADDR_W 3
`define OFS_SC 3'h0
`define OFS_CNT 3'h1
`define OFS_MOD 3'h2
`define OFS_IST 3'h3
`define OFS_IMSK 3'h4
`define FLAG_BIT 7
`define CLKS_HI 6
`define CLKS_LO 5
`define IE_BIT 4
`define PS_HI 3
`define PS_LO 0
`define BYTE_ZERO 8'h00
`define PS_OFF 4'h0
`define CLKS_LPO 2'h0
`define CLKS_EXT 2'h1
`define SRC_LPO 0
`define SRC_EXT 1
`define SRC_INT 2
`define DIV_W 18
`define DIV_CODES 16
`define DIV_ONE 18'h00001
`define PRE_ZERO 18'h00000
// Divide-by values, code 15 down to code 0; code 0 means stopped
`define DIV_LO_TBL {18'h003E8, 18'h001F4, 18'h00064, 18'h00010, \
    18'h0000A, 18'h00004, 18'h00002, 18'h00001, 18'h00400, 18'h00200, \
    18'h00100, 18'h00080, 18'h00040, 18'h00020, 18'h00008, 18'h00000}
`define DIV_HI_TBL {18'h30D40, 18'h186A0, 18'h0C350, 18'h04E20, \
    18'h02710, 18'h01388, 18'h007D0, 18'h003E8, 18'h10000, 18'h08000, \
    18'h04000, 18'h02000, 18'h01000, 18'h00800, 18'h00400, 18'h00000}
`endif

// ==== rtc_pkg.sv ====
// Types shared by the periodic wakeup counter.
// Assumes rtc_defines.svh is compiled alongside.
package rtc_pkg;
    typedef struct packed {
        logic match_flag;
        logic [1:0] clock_select_field;
        logic match_irq_enable;
        logic [3:0] prescaler_select_field;
    } status_control_t;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage : rtc_pkg

// ==== tb_periodic_wakeup_counter_regs.sv ====
// Self-checking bench for the periodic wakeup counter registers.
// Assumes rtc_pkg and rtc_defines.svh are compiled first; one clock.
`timescale 1ns/1ps
`include "rtc_defines.svh"

module tb_periodic_wakeup_counter_regs
    import rtc_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [2:0] src = 3'h0;
    logic debug_active = 1'b0;
    logic irq;
    logic [7:0] seed = 8'h18;
    logic [7:0] rv;
    int fails = 0;
    int comparisons = 0;
    // Source, prescaler code and divide-by, kept short to bound run time
    int tc[10] = '{0, 0, 0, 0, 0, 0, 1, 1, 2, 3};
    int tp[10] = '{8, 9, 10, 11, 1, 12, 8, 1, 10, 8};
    int td[10] = '{1, 2, 4, 10, 8, 16, 1000, 1024, 4, 1000};

    always #50 core_clk = ~core_clk;

    periodic_wakeup_counter_regs dut (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .low_power_1khz_oscillator(src[0]),
        .external_reference_clock(src[1]),
        .internal_reference_clock(src[2]),
        .debug_active(debug_active),
        .irq(irq)
    );

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // Select codes 2 and 3 both take the internal source
    function automatic int src_of(input int c);
        return (c > 1) ? 2 : c;
    endfunction : src_of

    function automatic logic [7:0] exp_count(input int n, input logic [7:0] m);
        return 8'(n % (int'(m) + 1));
    endfunction : exp_count

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd

    // Sources must stay no faster than half the core clock
    task automatic pulse(input int s, input int n);
        repeat (n) begin
            @(posedge core_clk);
            src[s] <= 1'b1;
            @(posedge core_clk);
            src[s] <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
    endtask : pulse

    task automatic irq_is(input logic [7:0] exp);
        repeat (2) @(posedge core_clk);
        #1;
        check({7'h00, irq}, exp);
    endtask : irq_is

    task automatic results();
        $display("Counts: %0d compared, %0d mismatched", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(`OFS_SC, 8'h00);
        rd(`OFS_MOD, 8'h00);
        rd(`OFS_CNT, 8'h00);
        wr(`OFS_CNT, 8'h5A);
        rd(`OFS_CNT, 8'h00);
        rd(3'h7, 8'h00);
        $display("Reset and access test done");
        wr(`OFS_MOD, 8'hFF);
        for (int i = 0; i < 10; i++) begin
            wr(`OFS_SC, {1'b0, 2'(tc[i]), 1'b0, 4'(tp[i])});
            rd(`OFS_CNT, 8'h00);
            pulse((src_of(tc[i]) + 1) % 3, 3);
            rd(`OFS_CNT, 8'h00);
            pulse(src_of(tc[i]), td[i] - 1);
            rd(`OFS_CNT, 8'h00);
            pulse(src_of(tc[i]), 1);
            rd(`OFS_CNT, 8'h01);
        end
        wr(`OFS_SC, 8'h00);
        pulse(0, 3);
        rd(`OFS_CNT, 8'h00);
        $display("Divider test done");
        wr(`OFS_SC, 8'h08);
        for (int i = 0; i < 6; i++) begin
            int n;
            seed = lfsr(seed);
            rv = seed & 8'h07;
            n = int'(lfsr(seed) & 8'h0F);
            wr(`OFS_MOD, rv);
            wr(`OFS_SC, 8'h88);
            rd(`OFS_MOD, rv);
            pulse(0, n);
            rd(`OFS_CNT, exp_count(n, rv));
            rd(`OFS_SC, {n > int'(rv), 7'h08});
        end
        $display("Modulo test done");
        wr(`OFS_MOD, 8'h00);
        wr(`OFS_SC, 8'h98);
        irq_is(8'h00);
        pulse(0, 1);
        irq_is(8'h01);
        wr(`OFS_SC, 8'h08);
        irq_is(8'h00);
        rd(`OFS_SC, 8'h88);
        wr(`OFS_SC, 8'h88);
        rd(`OFS_SC, 8'h08);
        rd(`OFS_IST, 8'h01);
        rd(`OFS_IST, 8'h00);
        wr(`OFS_IMSK, 8'h01);
        pulse(0, 1);
        irq_is(8'h01);
        rd(`OFS_IST, 8'h01);
        irq_is(8'h00);
        wr(`OFS_IMSK, 8'h00);
        $display("Interrupt test done");
        // Debug hold must not lose the count already reached
        wr(`OFS_MOD, 8'hFF);
        pulse(0, 3);
        debug_active <= 1'b1;
        pulse(0, 5);
        rd(`OFS_CNT, 8'h03);
        @(posedge core_clk);
        debug_active <= 1'b0;
        pulse(0, 2);
        rd(`OFS_CNT, 8'h05);
        $display("Debug test done");
        results();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        fails++;
        results();
    end
endmodule : tb_periodic_wakeup_counter_regs
